// ==== bvs_setpoint_select.sv ====
// Setpoint registers, select-pin steering and change start for two bucks.
module bvs_setpoint_select
    import bvs_pkg::*;
#(
    parameter int unsigned VARIANT = 0
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire bvs_reg_req_t          reg_req_i,
    output logic      [7:0]            reg_rdata_o,
    output logic                       reg_rvalid_o,
    input  wire logic                  undervoltage_lockout_i,
    input  wire logic                  buck2_level_select_pin_i,
    input  wire logic                  buck3_level_select_pin_i,
    input  wire logic                  buck2_nvm_ext_adj_i,
    input  wire logic                  buck3_nvm_ext_adj_i,
    output logic      [BVS_CODE_W-1:0] buck2_setpoint_code_o,
    output logic      [BVS_CODE_W-1:0] buck3_setpoint_code_o,
    output logic      [BVS_MV_W-1:0]   buck2_setpoint_mv_o,
    output logic      [BVS_MV_W-1:0]   buck3_setpoint_mv_o,
    output logic                       buck2_external_adjust_o,
    output logic                       buck3_external_adjust_o,
    output logic                       buck2_change_start_o,
    output logic                       buck3_change_start_o,
    output logic                       lockout_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (VARIANT >= BVS_NUM_VARIANT) begin : g_check
        $error("VARIANT must select one of the eight default tables.");
    end

    if (BVS_NUM_BUCKS != 2) begin : g_check_bucks
        $error("Only the second and third bucks are served.");
    end

    if (BVS_CODE_W != 6) begin : g_check_code
        $error("Setpoint codes must be six bits wide.");
    end

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    function automatic logic [3:0] addr_hit(input logic [7:0] a);
        addr_hit = 4'h0;
        case (a)
            BVS_ADDR_B2_LOW: begin
                addr_hit = 4'h1;
            end
            BVS_ADDR_B2_HIGH: begin
                addr_hit = 4'h2;
            end
            BVS_ADDR_B3_LOW: begin
                addr_hit = 4'h4;
            end
            BVS_ADDR_B3_HIGH: begin
                addr_hit = 4'h8;
            end
            default: begin
                addr_hit = 4'h0;
            end
        endcase
    endfunction

    // ****************************************************************
    // Register image
    // ****************************************************************
    function automatic logic [7:0] reg_image(input bvs_setpoint_t r);
        reg_image = {r.b7, 1'b0, r.code};
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam logic [5:0] LOW_DEF [BVS_NUM_BUCKS] =
        '{BVS_B2_LOW_DEF[VARIANT], BVS_B3_LOW_DEF[VARIANT]};
    localparam logic [5:0] HIGH_DEF [BVS_NUM_BUCKS] =
        '{BVS_B2_HIGH_DEF[VARIANT], BVS_B3_HIGH_DEF[VARIANT]};

    bvs_state_t                  state;
    bvs_state_t                  next_state;
    logic                        undervoltage_lockout_sync;
    logic                        lockout;
    logic [3:0]                  wr_hit;
    logic [3:0]                  rd_hit;
    logic [BVS_NUM_BUCKS-1:0]    pin_raw;
    logic [BVS_NUM_BUCKS-1:0]    nvm_raw;
    logic [BVS_NUM_BUCKS-1:0]    sel_sync;
    logic [BVS_NUM_BUCKS-1:0]    sel_edge;
    logic [BVS_NUM_BUCKS-1:0]    nvm_sync;
    logic [BVS_NUM_BUCKS-1:0]    wr_lo;
    logic [BVS_NUM_BUCKS-1:0]    wr_hi;
    logic [BVS_NUM_BUCKS-1:0]    wr_seen;
    logic [BVS_NUM_BUCKS-1:0]    change;
    logic [BVS_NUM_BUCKS-1:0]    ext_adj;
    bvs_setpoint_t               lo_reg [BVS_NUM_BUCKS];
    bvs_setpoint_t               hi_reg [BVS_NUM_BUCKS];
    logic [BVS_CODE_W-1:0]       applied [BVS_NUM_BUCKS];
    logic [BVS_MV_W-1:0]         applied_mv [BVS_NUM_BUCKS];
    logic [7:0]                  next_rdata;

    assign pin_raw = {buck3_level_select_pin_i, buck2_level_select_pin_i};
    assign nvm_raw = {buck3_nvm_ext_adj_i, buck2_nvm_ext_adj_i};

    assign wr_hit = reg_req_i.wr ? addr_hit(reg_req_i.addr) : 4'h0;
    assign rd_hit = addr_hit(reg_req_i.addr);

    // ****************************************************************
    // Lockout tracking
    // ****************************************************************
    bvs_pin_sync #(
        .STAGES  (BVS_SYNC_STAGES),
        .RST_VAL (BVS_LOCKOUT_SYNC_RST)
    ) u_undervoltage_lockout_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (undervoltage_lockout_i),
        .q_o     (undervoltage_lockout_sync),
        .edge_o  ()
    );

    always_comb begin
        next_state = state;
        case (state)
            BVS_ST_LOCKOUT: begin
                if (!undervoltage_lockout_sync) begin
                    next_state = BVS_ST_RUN;
                end
            end
            BVS_ST_RUN: begin
                if (undervoltage_lockout_sync) begin
                    next_state = BVS_ST_LOCKOUT;
                end
            end
            default: begin
                next_state = BVS_ST_LOCKOUT;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= BVS_ST_LOCKOUT;
        end else begin
            state <= next_state;
        end
    end

    assign lockout   = (state == BVS_ST_LOCKOUT);
    assign lockout_o = lockout;

    // ****************************************************************
    // Per-converter logic
    // ****************************************************************
    for (genvar g = 0; g < BVS_NUM_BUCKS; g++) begin : g_buck

        bvs_pin_sync #(
            .STAGES (BVS_SYNC_STAGES)
        ) u_sel_sync (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .d_i     (pin_raw[g]),
            .q_o     (sel_sync[g]),
            .edge_o  (sel_edge[g])
        );

        bvs_pin_sync #(
            .STAGES (BVS_SYNC_STAGES)
        ) u_nvm_sync (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .d_i     (nvm_raw[g]),
            .q_o     (nvm_sync[g]),
            .edge_o  ()
        );

        // Writes are ignored while lockout holds.
        assign wr_lo[g] = wr_hit[2*g] && !lockout;
        assign wr_hi[g] = wr_hit[2*g+1] && !lockout;

        // Low setpoint register.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                lo_reg[g] <= '{b7: 1'b0, code: LOW_DEF[g]};
            end else if (lockout) begin
                lo_reg[g] <= '{b7: 1'b0, code: LOW_DEF[g]};
            end else if (wr_lo[g]) begin
                lo_reg[g].code <= reg_req_i.wdata[BVS_CODE_W-1:0];
                lo_reg[g].b7   <= reg_req_i.wdata[BVS_LOW_B7_BIT] & BVS_LOW_B7_RW[g];
            end
        end

        // High setpoint register with the external-adjust flag.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                hi_reg[g] <= '{b7: BVS_EXT_ADJ_RST, code: HIGH_DEF[g]};
            end else if (lockout) begin
                hi_reg[g] <= '{b7: nvm_sync[g], code: HIGH_DEF[g]};
            end else if (wr_hi[g]) begin
                hi_reg[g].code <= reg_req_i.wdata[BVS_CODE_W-1:0];
                hi_reg[g].b7   <= reg_req_i.wdata[BVS_EXT_ADJ_BIT];
            end
        end

        // Applied setpoint follows the synchronised select pin.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                applied[g] <= LOW_DEF[g];
            end else if (sel_sync[g]) begin
                applied[g] <= hi_reg[g].code;
            end else begin
                applied[g] <= lo_reg[g].code;
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                ext_adj[g] <= BVS_EXT_ADJ_RST;
            end else begin
                ext_adj[g] <= hi_reg[g].b7;
            end
        end

        // Change start lines up with the new applied code.
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                wr_seen[g] <= 1'b0;
            end else begin
                wr_seen[g] <= wr_lo[g] | wr_hi[g];
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                change[g] <= 1'b0;
            end else begin
                change[g] <= (sel_edge[g] | wr_seen[g]) & !lockout;
            end
        end

        bvs_code_decode u_decode (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .code_i  (applied[g]),
            .mv_o    (applied_mv[g])
        );
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    // Unused bit six always reads as zero.
    always_comb begin
        next_rdata = BVS_RDATA_RESET;
        case (rd_hit)
            4'h1: begin
                next_rdata = reg_image(lo_reg[0]);
            end
            4'h2: begin
                next_rdata = reg_image(hi_reg[0]);
            end
            4'h4: begin
                next_rdata = reg_image(lo_reg[1]);
            end
            4'h8: begin
                next_rdata = reg_image(hi_reg[1]);
            end
            default: begin
                next_rdata = BVS_RDATA_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= BVS_RDATA_RESET;
        end else if (reg_req_i.rd) begin
            reg_rdata_o <= next_rdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign buck2_setpoint_code_o   = applied[0];
    assign buck3_setpoint_code_o   = applied[1];
    assign buck2_setpoint_mv_o     = applied_mv[0];
    assign buck3_setpoint_mv_o     = applied_mv[1];
    assign buck2_external_adjust_o = ext_adj[0];
    assign buck3_external_adjust_o = ext_adj[1];
    assign buck2_change_start_o    = change[0];
    assign buck3_change_start_o    = change[1];

endmodule

// ==== bvs_pkg.sv ====
// Constants, types and default tables for the buck setpoint selection bank.
// How it works
// - Second buck uses its low setpoint when its select pin is low, else high.
// - Third buck uses its low setpoint when its select pin is low, else high.
// - Second buck fixed by default; nonvolatile option sets external-adjust bit B7 of high.
// - Third buck likewise; external-adjust bit B7 of its high register from nonvolatile option.
// - Codes 0 to 31 decode from 0.725 V in 25 mV steps to 1.500 V.
// - Codes 32 to 59 decode from 1.550 V in 50 mV steps to 2.900 V.
// - Codes 60 to 63 decode from 3.000 V in 100 mV steps to 3.300 V.
// - Lockout loads variant defaults into all setpoint codes and the nonvolatile option into the high-register adjust bits; unused bits read zero,
// except B7 of the third buck's low register, which reads back as written.
// - Outside lockout, select pin edges and setpoint rewrites start a voltage change in the cycle the new code is applied.
package bvs_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int unsigned BVS_NUM_BUCKS   = 2;
    localparam int unsigned BVS_NUM_VARIANT = 8;
    localparam int unsigned BVS_SYNC_STAGES = 2;
    localparam int unsigned BVS_CODE_W      = 6;
    localparam int unsigned BVS_MV_W        = 12;

    // ****************************************************************
    // Register offsets and fields
    // ****************************************************************
    localparam logic [7:0] BVS_ADDR_B2_LOW  = 8'h11;
    localparam logic [7:0] BVS_ADDR_B2_HIGH = 8'h12;
    localparam logic [7:0] BVS_ADDR_B3_LOW  = 8'h13;
    localparam logic [7:0] BVS_ADDR_B3_HIGH = 8'h14;
    localparam int unsigned BVS_EXT_ADJ_BIT = 7;
    localparam int unsigned BVS_LOW_B7_BIT  = 7;
    localparam logic [1:0] BVS_LOW_B7_RW    = 2'h2;
    localparam logic [7:0] BVS_RDATA_RESET  = 8'h00;
    localparam logic       BVS_EXT_ADJ_RST  = 1'b0;
    localparam logic       BVS_LOCKOUT_SYNC_RST = 1'b1;

    // ****************************************************************
    // Setpoint code decoding in millivolts
    // ****************************************************************
    localparam logic [5:0]  BVS_CODE_MID     = 6'h20;
    localparam logic [5:0]  BVS_CODE_TOP     = 6'h3C;
    localparam logic [11:0] BVS_MV_BASE_LOW  = 12'h2D5;
    localparam logic [11:0] BVS_MV_STEP_LOW  = 12'h019;
    localparam logic [11:0] BVS_MV_BASE_MID  = 12'h60E;
    localparam logic [11:0] BVS_MV_STEP_MID  = 12'h032;
    localparam logic [11:0] BVS_MV_BASE_TOP  = 12'hBB8;
    localparam logic [11:0] BVS_MV_STEP_TOP  = 12'h064;

    // ****************************************************************
    // Variant default codes, index 0 to 7
    // ****************************************************************
    localparam logic [5:0] BVS_B2_LOW_DEF [BVS_NUM_VARIANT] =
        '{6'h25, 6'h25, 6'h13, 6'h13, 6'h25, 6'h25, 6'h25, 6'h2B};
    localparam logic [5:0] BVS_B2_HIGH_DEF [BVS_NUM_VARIANT] =
        '{6'h3F, 6'h33, 6'h25, 6'h25, 6'h3F, 6'h3F, 6'h3F, 6'h2B};
    localparam logic [5:0] BVS_B3_LOW_DEF [BVS_NUM_VARIANT] =
        '{6'h0B, 6'h13, 6'h13, 6'h13, 6'h13, 6'h25, 6'h25, 6'h39};
    localparam logic [5:0] BVS_B3_HIGH_DEF [BVS_NUM_VARIANT] =
        '{6'h13, 6'h1B, 6'h19, 6'h19, 6'h19, 6'h3F, 6'h3F, 6'h39};

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bvs_reg_req_t;

    typedef struct packed {
        logic       b7;
        logic [5:0] code;
    } bvs_setpoint_t;

    typedef enum logic [0:0] {
        BVS_ST_LOCKOUT = 1'b0,
        BVS_ST_RUN     = 1'b1
    } bvs_state_t;

endpackage

// ==== bvs_pin_sync.sv ====
// Two-stage synchroniser with an edge pulse taken from the settled stage.
module bvs_pin_sync
    import bvs_pkg::*;
#(
    parameter int unsigned STAGES  = BVS_SYNC_STAGES,
    parameter logic        RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o,
    output logic      edge_o
);

    logic [STAGES-1:0] chain;
    logic              last;

    if (STAGES < 2) begin : g_check
        $error("Synchroniser needs at least two stages.");
    end

    // ****************************************************************
    // Synchroniser chain
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chain <= {STAGES{RST_VAL}};
        end else begin
            chain <= {chain[STAGES-2:0], d_i};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last <= RST_VAL;
        end else begin
            last <= chain[STAGES-1];
        end
    end

    assign q_o    = chain[STAGES-1];
    assign edge_o = chain[STAGES-1] ^ last;

endmodule

// ==== bvs_code_decode.sv ====
// Registered decoder from a 6-bit setpoint code to millivolts.
module bvs_code_decode
    import bvs_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic [BVS_CODE_W-1:0] code_i,
    output logic      [BVS_MV_W-1:0]   mv_o
);

    function automatic logic [BVS_MV_W-1:0] code_to_mv(input logic [5:0] c);
        logic [11:0] idx;
        idx = {6'h00, c};
        if (c < BVS_CODE_MID) begin
            code_to_mv = 12'(BVS_MV_BASE_LOW + idx * BVS_MV_STEP_LOW);
        end else if (c < BVS_CODE_TOP) begin
            code_to_mv = 12'(BVS_MV_BASE_MID
                + (idx - {6'h00, BVS_CODE_MID}) * BVS_MV_STEP_MID);
        end else begin
            code_to_mv = 12'(BVS_MV_BASE_TOP
                + (idx - {6'h00, BVS_CODE_TOP}) * BVS_MV_STEP_TOP);
        end
    endfunction

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mv_o <= BVS_MV_BASE_LOW;
        end else begin
            mv_o <= code_to_mv(code_i);
        end
    end

endmodule

// ==== bvs_select_asserts.sv ====
// Concurrent checks on the ports of the buck setpoint selection bank.
module bvs_select_asserts
    import bvs_pkg::*;
(
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire bvs_reg_req_t          reg_req_i,
    input wire logic [7:0]            reg_rdata_o,
    input wire logic                  reg_rvalid_o,
    input wire logic                  undervoltage_lockout_i,
    input wire logic                  buck2_level_select_pin_i,
    input wire logic                  buck3_level_select_pin_i,
    input wire logic [BVS_CODE_W-1:0] buck2_setpoint_code_o,
    input wire logic [BVS_CODE_W-1:0] buck3_setpoint_code_o,
    input wire logic [BVS_MV_W-1:0]   buck2_setpoint_mv_o,
    input wire logic                  buck2_external_adjust_o,
    input wire logic                  buck2_change_start_o,
    input wire logic                  lockout_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Properties and assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    function automatic logic [11:0] dec(input logic [5:0] c);
        if (c < 6'h20) return 12'h2D5 + 12'(c) * 12'h019;
        if (c < 6'h3C) return 12'h60E + 12'(c - 6'h20) * 12'h032;
        return 12'hBB8 + 12'(c - 6'h3C) * 12'h064;
    endfunction

    sequence wr_s(a);
        reg_req_i.wr && reg_req_i.addr == a && !lockout_o;
    endsequence
    sequence pin_s(p, v);
        (p == v) [*3];
    endsequence
    property apply_p(p, v, a, c);
        pin_s(p, v) ##0 wr_s(a) |-> ##2 c == $past(reg_req_i.wdata[5:0], 2);
    endproperty

    rsvd_bits_a: assert property (
        reg_req_i.rd && reg_req_i.addr inside {8'h11, 8'h12, 8'h13, 8'h14} |=> reg_rvalid_o
        && !reg_rdata_o[6] && !(reg_rdata_o[7] && $past(reg_req_i.addr) == 8'h11))
        else $error("reserved bits not zero");
    b2_low_apply_a: assert property (
        apply_p(buck2_level_select_pin_i, 1'b0, 8'h11, buck2_setpoint_code_o))
        else $error("buck2 low setpoint not applied");
    b2_high_apply_a: assert property (
        apply_p(buck2_level_select_pin_i, 1'b1, 8'h12, buck2_setpoint_code_o))
        else $error("buck2 high setpoint not applied");
    b3_high_apply_a: assert property (
        apply_p(buck3_level_select_pin_i, 1'b1, 8'h14, buck3_setpoint_code_o))
        else $error("buck3 high setpoint not applied");
    b2_mv_a: assert property (
        $past(rst_n_i) |-> buck2_setpoint_mv_o == dec($past(buck2_setpoint_code_o)))
        else $error("buck2 voltage decode wrong");
    b2_ext_a: assert property (
        wr_s(8'h12) |-> ##2 buck2_external_adjust_o == $past(reg_req_i.wdata[7], 2))
        else $error("buck2 external adjust wrong");
    b2_pin_chg_a: assert property (
        $changed(buck2_level_select_pin_i) && !lockout_o ##1 !lockout_o [*2]
        |=> buck2_change_start_o) else $error("buck2 pin change not started");
    b2_write_chg_a: assert property (
        (wr_s(8'h11) or wr_s(8'h12)) ##1 !lockout_o |-> ##1 buck2_change_start_o)
        else $error("buck2 write change not started");
    lock_in_a: assert property (undervoltage_lockout_i [*5] |-> lockout_o)
        else $error("lockout not entered");
    lock_out_a: assert property (!undervoltage_lockout_i [*5] |-> !lockout_o)
        else $error("lockout not left");
endmodule

bind bvs_setpoint_select bvs_select_asserts bvs_select_asserts_inst (.*);

// ==== bvs_host_model.sv ====
// Host model that issues register accesses to the setpoint bank.
module bvs_host_model
    import bvs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output bvs_reg_req_t    req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Access tasks
    // ****************************************
    initial req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

    // Released address and data lines show the inverse of the last value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 3 && !ok; i++) begin
            @(negedge clk_i);
            ok = (rvalid_i === 1'b1);
            d = rdata_i;
        end
    endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the buck setpoint selection bank.
`define CHK(n, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error %s expected %0h seen %0h", n, e, g); \
    end \
end

module testbench
    import bvs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned V = 1;
    logic         clk_i = 1'b0, rst_n_i = 1'b0, undervoltage_lockout_i = 1'b1;
    logic         pin2 = 1'b0, pin3 = 1'b0, nvm2 = 1'b1, nvm3 = 1'b0;
    logic         rvalid, ext2, ext3, chg2, chg3, lock;
    logic [7:0]   rdata;
    logic [5:0]   code2, code3;
    logic [11:0]  mv2, mv3;
    bvs_reg_req_t req;
    int           mismatches = 0, comparisons = 0;
    logic [5:0]   codes [6] = '{6'h00, 6'h1F, 6'h20, 6'h3B, 6'h3C, 6'h3F};
    logic [11:0]  mvs [6] = '{12'h2D5, 12'h5DC, 12'h60E, 12'hB54, 12'hBB8, 12'hCE4};

    // ****************************************
    // Design, host and checks
    // ****************************************
    always #5ns clk_i = ~clk_i;

    bvs_setpoint_select #(.VARIANT(V)) bvs_setpoint_select_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .undervoltage_lockout_i(undervoltage_lockout_i), .buck2_level_select_pin_i(pin2),
        .buck3_level_select_pin_i(pin3), .buck2_nvm_ext_adj_i(nvm2),
        .buck3_nvm_ext_adj_i(nvm3), .buck2_setpoint_code_o(code2),
        .buck3_setpoint_code_o(code3), .buck2_setpoint_mv_o(mv2), .buck3_setpoint_mv_o(mv3),
        .buck2_external_adjust_o(ext2), .buck3_external_adjust_o(ext3),
        .buck2_change_start_o(chg2), .buck3_change_start_o(chg3), .lockout_o(lock));

    bvs_host_model bvs_host_model_inst (
        .clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        bvs_host_model_inst.rd(a, d, ok);
        if (ok !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        `CHK("rdata", e, d)
    endtask

    task automatic wait_lock(input logic u);
        @(posedge clk_i);
        undervoltage_lockout_i <= u;
        repeat (6) @(posedge clk_i);
        `CHK("lockout", u, lock)
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wait_lock(1'b0);
        rdchk(BVS_ADDR_B2_LOW, {2'h0, BVS_B2_LOW_DEF[V]});
        rdchk(BVS_ADDR_B2_HIGH, {nvm2, 1'b0, BVS_B2_HIGH_DEF[V]});
        rdchk(BVS_ADDR_B3_LOW, {2'h0, BVS_B3_LOW_DEF[V]});
        rdchk(BVS_ADDR_B3_HIGH, {nvm3, 1'b0, BVS_B3_HIGH_DEF[V]});
        rdchk(8'h15, 8'h00);
        `CHK("code2", BVS_B2_LOW_DEF[V], code2)
        `CHK("ext2", 1'b1, ext2)
        `CHK("ext3", 1'b0, ext3)
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 6; i++) begin
                bvs_host_model_inst.wr(b ? BVS_ADDR_B3_LOW : BVS_ADDR_B2_LOW, {2'h0, codes[i]});
                repeat (2) @(negedge clk_i);
                `CHK("code", codes[i], b ? code3 : code2)
                `CHK("change", 1'b1, b ? chg3 : chg2)
                @(negedge clk_i);
                `CHK("mv", mvs[i], b ? mv3 : mv2)
            end
        end
        bvs_host_model_inst.wr(BVS_ADDR_B2_LOW, 8'hFF);
        rdchk(BVS_ADDR_B2_LOW, 8'h3F);
        bvs_host_model_inst.wr(BVS_ADDR_B3_LOW, 8'hFF);
        rdchk(BVS_ADDR_B3_LOW, 8'hBF);
        @(posedge clk_i);
        pin2 <= 1'b1;
        pin3 <= 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK("code2", 6'h3F, code2)
        @(negedge clk_i);
        `CHK("code2", BVS_B2_HIGH_DEF[V], code2)
        `CHK("code3", BVS_B3_HIGH_DEF[V], code3)
        `CHK("change", 1'b1, chg3)
        bvs_host_model_inst.wr(BVS_ADDR_B2_HIGH, 8'h85);
        repeat (3) @(negedge clk_i);
        `CHK("ext2", 1'b1, ext2)
        `CHK("mv2", 12'h352, mv2)
        bvs_host_model_inst.wr(BVS_ADDR_B2_HIGH, 8'h05);
        bvs_host_model_inst.wr(BVS_ADDR_B3_HIGH, 8'h80);
        repeat (3) @(negedge clk_i);
        `CHK("ext2", 1'b0, ext2)
        `CHK("ext3", 1'b1, ext3)
        rdchk(BVS_ADDR_B3_HIGH, 8'h80);
        @(posedge clk_i);
        pin2 <= 1'b0;
        nvm2 <= 1'b0;
        nvm3 <= 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK("code2", 6'h3F, code2)
        wait_lock(1'b1);
        bvs_host_model_inst.wr(BVS_ADDR_B2_LOW, 8'h01);
        rdchk(BVS_ADDR_B2_LOW, {2'h0, BVS_B2_LOW_DEF[V]});
        wait_lock(1'b0);
        rdchk(BVS_ADDR_B2_HIGH, {nvm2, 1'b0, BVS_B2_HIGH_DEF[V]});
        rdchk(BVS_ADDR_B3_HIGH, {nvm3, 1'b0, BVS_B3_HIGH_DEF[V]});
        rdchk(BVS_ADDR_B3_LOW, {2'h0, BVS_B3_LOW_DEF[V]});
        give_verdict();
    end
endmodule
